// ==== hw/pec_pkg.sv ====
// Shared constants and carrier types for the enable and configuration register bank
package pec_pkg;
    // ------------------------------------------------------------------
    // Bus geometry and register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] IDX_PASSWORD = 8'h10;
    localparam logic [7:0] IDX_OUTPUT_ENABLE_CTRL = 8'h12;
    localparam logic [7:0] IDX_SYSTEM_CONFIG_A = 8'h13;
    localparam logic [7:0] IDX_SYSTEM_CONFIG_B = 8'h14;
    localparam logic [7:0] PW_KEY = 8'h7d;
    // ------------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_OUTPUT_ENABLE_CTRL = 8'h00;
    localparam logic [7:0] RST_SYSTEM_CONFIG_A = 8'h48;
    localparam logic [7:0] RST_SYSTEM_CONFIG_B = 8'hc0;
    localparam logic [7:0] MASK_OUTPUT_ENABLE_CTRL = 8'h7f;
    localparam logic [7:0] MASK_SYSTEM_CONFIG_A = 8'hff;
    localparam logic [7:0] MASK_SYSTEM_CONFIG_B = 8'hcf;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OE_GENERAL_OUT_THREE = 6;
    localparam int OE_GENERAL_OUT_TWO_CTL = 5;
    localparam int OE_GENERAL_OUT_ONE_CTL = 4;
    localparam int OE_SWITCH_THREE_ENABLE = 3;
    localparam int OE_SWITCH_TWO_ENABLE = 2;
    localparam int OE_SWITCH_ONE_ENABLE = 1;
    localparam int OE_LINEAR_REG_ENABLE = 0;
    localparam int CA_PB_RESET_TIME = 7;
    localparam int CA_SECOND_OUTPUT_BUFFER_TYPE = 6;
    localparam int CA_FIRST_PIN_INPUT_SELECT = 5;
    localparam int CA_POWER_GOOD_DELAY_LO = 3;
    localparam int CA_SUPERVISOR_TIGHT_LIMITS = 2;
    localparam int CA_UNDERVOLT_LO = 0;
    localparam int CB_WARM_RESET_PIN_SELECT = 7;
    localparam int CB_UNDERVOLT_HYST = 6;
    localparam int CB_SWITCH_THREE_CURRENT_LIMIT_LO = 2;
    localparam int CB_SWITCH_TWO_CURRENT_LIMIT_LO = 0;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ = 125000000;
    localparam longint PB_SHORT_S = 8;
    localparam longint PB_LONG_S = 15;
    localparam longint PGD_0_MS = 10;
    localparam longint PGD_1_MS = 20;
    localparam longint PGD_2_MS = 50;
    localparam longint PGD_3_MS = 150;
    localparam longint PB_SHORT_CYC_DEF = PB_SHORT_S * CLK_HZ;
    localparam longint PB_LONG_CYC_DEF = PB_LONG_S * CLK_HZ;
    localparam longint PGD_0_CYC_DEF = PGD_0_MS * CLK_HZ / 1000;
    localparam longint PGD_1_CYC_DEF = PGD_1_MS * CLK_HZ / 1000;
    localparam longint PGD_2_CYC_DEF = PGD_2_MS * CLK_HZ / 1000;
    localparam longint PGD_3_CYC_DEF = PGD_3_MS * CLK_HZ / 1000;
    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [DATA_W-1:0] dat;
    } pec_wb_req_t;
    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] dat;
    } pec_wb_rsp_t;
    typedef struct packed {
        logic g1;
        logic g3;
        logic pb_n;
        logic pg_in;
    } pec_pin_in_t;
    typedef struct packed {
        logic g1_o;
        logic g1_oe;
        logic g2_o;
        logic g2_oe;
        logic g3_o;
        logic g3_oe;
    } pec_pins_t;
    typedef struct packed {
        logic switch_three_enable;
        logic switch_two_enable;
        logic switch_one_enable;
        logic linear_reg_enable;
        logic [1:0] power_good_delay;
        logic supervisor_tight_limits;
        logic overvolt_monitor_en;
        logic [1:0] undervolt_level;
        logic undervolt_hyst;
        logic [1:0] switch_three_current_limit;
        logic [1:0] switch_two_current_limit;
        logic warm_reset_pin_select;
        logic first_pin_input_select;
    } pec_cfg_t;
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] cfga;
        logic [7:0] cfgb;
        logic unlock;
        logic ack;
        logic [7:0] rdata;
        logic [2:0] io1_s;
        logic [2:0] g3_s;
        logic [2:0] pb_s;
        logic [2:0] pg_s;
        logic io1_lvl;
        logic g3_lvl;
        logic pb_lvl;
        logic pg_lvl;
        logic [31:0] pb_cnt;
        logic pb_done;
        logic pb_rst;
        logic [31:0] pg_cnt;
        logic pgood;
    } pec_state_t;
endpackage : pec_pkg

// ==== hw/pec_regs.sv ====
// Enable and configuration register bank with pin control, push-button and power-good timers
`timescale 1ns/10ps
module pec_regs #(
    parameter logic [31:0] PB_SHORT_CYC = 32'(pec_pkg::PB_SHORT_CYC_DEF),
    parameter logic [31:0] PB_LONG_CYC = 32'(pec_pkg::PB_LONG_CYC_DEF),
    parameter logic [31:0] PGD_0_CYC = 32'(pec_pkg::PGD_0_CYC_DEF),
    parameter logic [31:0] PGD_1_CYC = 32'(pec_pkg::PGD_1_CYC_DEF),
    parameter logic [31:0] PGD_2_CYC = 32'(pec_pkg::PGD_2_CYC_DEF),
    parameter logic [31:0] PGD_3_CYC = 32'(pec_pkg::PGD_3_CYC_DEF)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pec_pkg::pec_wb_req_t wb_req_i,
    output pec_pkg::pec_wb_rsp_t wb_rsp_o,
    input wire pec_pkg::pec_pin_in_t pin_i,
    output pec_pkg::pec_pins_t pins_o,
    input wire logic seq_update_i,
    input wire logic seq_ldo_en_i,
    input wire logic seq_switch_one_enable_i,
    output pec_pkg::pec_cfg_t cfg_o,
    output logic dcdc12_warm_rst_o,
    output logic pb_reset_o,
    output logic power_good_o
);
    import pec_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(logic [ADDR_W-1:0] adr, logic [7:0] idx);
        return adr == ADDR_W'({idx, 2'b00});
    endfunction : hit

    // Stage 0 feeds stage 1 only; the level moves once stages 1 and 2 agree
    function automatic logic [2:0] sync_shift(logic [2:0] s, logic pin);
        return {s[1], s[0], pin};
    endfunction : sync_shift

    function automatic logic settle(logic [2:0] s, logic old);
        return (s[1] == s[2]) ? s[2] : old;
    endfunction : settle

    function automatic logic [31:0] pg_limit(logic [1:0] code);
        logic [31:0] r;
        case (code)
            2'b00: r = PGD_0_CYC;
            2'b01: r = PGD_1_CYC;
            2'b10: r = PGD_2_CYC;
            default: r = PGD_3_CYC;
        endcase
        return r;
    endfunction : pg_limit

    localparam pec_state_t RST_STATE = '{
        oe: RST_OUTPUT_ENABLE_CTRL,
        cfga: RST_SYSTEM_CONFIG_A,
        cfgb: RST_SYSTEM_CONFIG_B,
        unlock: 1'b0,
        ack: 1'b0,
        rdata: 8'h00,
        io1_s: 3'h0,
        g3_s: 3'h7,
        pb_s: 3'h7,
        pg_s: 3'h0,
        io1_lvl: 1'b0,
        g3_lvl: 1'b1,
        pb_lvl: 1'b1,
        pg_lvl: 1'b0,
        pb_cnt: 32'h0,
        pb_done: 1'b0,
        pb_rst: 1'b0,
        pg_cnt: 32'h0,
        pgood: 1'b0
    };

    pec_state_t s_q;
    pec_state_t s_d;
    logic acc;
    logic wr_ok;
    logic [31:0] pb_lim;
    logic [31:0] pg_lim;

    // Ack low gates the access so a held strobe is not taken in two consecutive cycles; it is taken again every second cycle
    assign acc = wb_req_i.cyc && wb_req_i.stb && !s_q.ack;
    assign wr_ok = acc && wb_req_i.we && wb_req_i.sel[0];
    assign pb_lim = s_q.cfga[CA_PB_RESET_TIME] ? PB_LONG_CYC : PB_SHORT_CYC;
    assign pg_lim = pg_limit(s_q.cfga[CA_POWER_GOOD_DELAY_LO +: 2]);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = acc;
        s_d.pb_rst = 1'b0;

        s_d.io1_s = sync_shift(s_q.io1_s, pin_i.g1);
        s_d.g3_s = sync_shift(s_q.g3_s, pin_i.g3);
        s_d.pb_s = sync_shift(s_q.pb_s, pin_i.pb_n);
        s_d.pg_s = sync_shift(s_q.pg_s, pin_i.pg_in);
        s_d.io1_lvl = settle(s_q.io1_s, s_q.io1_lvl);
        s_d.g3_lvl = settle(s_q.g3_s, s_q.g3_lvl);
        s_d.pb_lvl = settle(s_q.pb_s, s_q.pb_lvl);
        s_d.pg_lvl = settle(s_q.pg_s, s_q.pg_lvl);

        // One pulse per press; a longer hold does not fire again
        if (s_q.pb_lvl) begin
            s_d.pb_cnt = 32'h0;
            s_d.pb_done = 1'b0;
        end else if (!s_q.pb_done) begin
            if (s_q.pb_cnt >= pb_lim - 32'h1) begin
                s_d.pb_done = 1'b1;
                s_d.pb_rst = 1'b1;
            end else begin
                s_d.pb_cnt = s_q.pb_cnt + 32'h1;
            end
        end

        // Delay on the rising edge only; a fault drops power-good at once
        if (!s_q.pg_lvl) begin
            s_d.pgood = 1'b0;
            s_d.pg_cnt = 32'h0;
        end else if (!s_q.pgood) begin
            if (s_q.pg_cnt >= pg_lim - 32'h1) begin
                s_d.pgood = 1'b1;
            end else begin
                s_d.pg_cnt = s_q.pg_cnt + 32'h1;
            end
        end

        if (acc && !wb_req_i.we) begin
            if (hit(wb_req_i.adr, IDX_OUTPUT_ENABLE_CTRL)) begin
                s_d.rdata = s_q.oe & MASK_OUTPUT_ENABLE_CTRL;
            end else if (hit(wb_req_i.adr, IDX_SYSTEM_CONFIG_A)) begin
                s_d.rdata = s_q.cfga & MASK_SYSTEM_CONFIG_A;
            end else if (hit(wb_req_i.adr, IDX_SYSTEM_CONFIG_B)) begin
                s_d.rdata = s_q.cfgb & MASK_SYSTEM_CONFIG_B;
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        // The key arms one protected write; any other write disarms it
        if (wr_ok) begin
            if (hit(wb_req_i.adr, IDX_PASSWORD)) begin
                s_d.unlock = (wb_req_i.dat[7:0] == PW_KEY);
            end else begin
                s_d.unlock = 1'b0;
                if (s_q.unlock) begin
                    if (hit(wb_req_i.adr, IDX_OUTPUT_ENABLE_CTRL)) begin
                        s_d.oe = wb_req_i.dat[7:0] & MASK_OUTPUT_ENABLE_CTRL;
                    end
                    if (hit(wb_req_i.adr, IDX_SYSTEM_CONFIG_A)) begin
                        s_d.cfga = wb_req_i.dat[7:0] & MASK_SYSTEM_CONFIG_A;
                    end
                    if (hit(wb_req_i.adr, IDX_SYSTEM_CONFIG_B)) begin
                        s_d.cfgb = wb_req_i.dat[7:0] & MASK_SYSTEM_CONFIG_B;
                    end
                end
            end
        end

        // Sequencer comes last so it wins over a same-cycle bus write
        if (seq_update_i) begin
            s_d.oe[OE_LINEAR_REG_ENABLE] = seq_ldo_en_i;
            s_d.oe[OE_SWITCH_ONE_ENABLE] = seq_switch_one_enable_i;
        end
    end

    // Synchronous reset restores every field and locks the bank again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic g2_src;
    assign g2_src = s_q.cfga[CA_FIRST_PIN_INPUT_SELECT] ? s_q.io1_lvl
                                                        : s_q.oe[OE_GENERAL_OUT_TWO_CTL];

    assign wb_rsp_o.ack = s_q.ack;
    assign wb_rsp_o.dat = {24'h000000, s_q.rdata};

    assign pins_o.g3_o = 1'b0;
    assign pins_o.g3_oe = !s_q.cfgb[CB_WARM_RESET_PIN_SELECT]
                          && !s_q.oe[OE_GENERAL_OUT_THREE];
    assign pins_o.g1_o = 1'b0;
    assign pins_o.g1_oe = !s_q.cfga[CA_FIRST_PIN_INPUT_SELECT]
                          && !s_q.oe[OE_GENERAL_OUT_ONE_CTL];
    // A high level is driven only by the push-pull buffer; open-drain releases it
    assign pins_o.g2_o = g2_src;
    assign pins_o.g2_oe = !g2_src || s_q.cfga[CA_SECOND_OUTPUT_BUFFER_TYPE];

    assign cfg_o.switch_three_enable = s_q.oe[OE_SWITCH_THREE_ENABLE];
    assign cfg_o.switch_two_enable = s_q.oe[OE_SWITCH_TWO_ENABLE];
    assign cfg_o.switch_one_enable = s_q.oe[OE_SWITCH_ONE_ENABLE];
    assign cfg_o.linear_reg_enable = s_q.oe[OE_LINEAR_REG_ENABLE];
    assign cfg_o.power_good_delay = s_q.cfga[CA_POWER_GOOD_DELAY_LO +: 2];
    assign cfg_o.supervisor_tight_limits = s_q.cfga[CA_SUPERVISOR_TIGHT_LIMITS];
    assign cfg_o.overvolt_monitor_en = s_q.cfga[CA_SUPERVISOR_TIGHT_LIMITS];
    assign cfg_o.undervolt_level = s_q.cfga[CA_UNDERVOLT_LO +: 2];
    assign cfg_o.undervolt_hyst = s_q.cfgb[CB_UNDERVOLT_HYST];
    assign cfg_o.switch_three_current_limit = s_q.cfgb[CB_SWITCH_THREE_CURRENT_LIMIT_LO +: 2];
    assign cfg_o.switch_two_current_limit = s_q.cfgb[CB_SWITCH_TWO_CURRENT_LIMIT_LO +: 2];
    assign cfg_o.warm_reset_pin_select = s_q.cfgb[CB_WARM_RESET_PIN_SELECT];
    assign cfg_o.first_pin_input_select = s_q.cfga[CA_FIRST_PIN_INPUT_SELECT];

    // Warm reset is active while the pin sits low in input mode
    assign dcdc12_warm_rst_o = s_q.cfgb[CB_WARM_RESET_PIN_SELECT] && !s_q.g3_lvl;
    assign pb_reset_o = s_q.pb_rst;
    assign power_good_o = s_q.pgood;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic prot_hit;
    assign prot_hit = hit(wb_req_i.adr, IDX_OUTPUT_ENABLE_CTRL)
                      || hit(wb_req_i.adr, IDX_SYSTEM_CONFIG_A)
                      || hit(wb_req_i.adr, IDX_SYSTEM_CONFIG_B);

    chk_third_pin_mode: assert property (
        s_q.cfgb[CB_WARM_RESET_PIN_SELECT] |-> !pins_o.g3_oe)
        else $error("third pin driven while in warm-reset input mode");

    chk_third_pin_drive: assert property (
        !s_q.cfgb[CB_WARM_RESET_PIN_SELECT] && !s_q.oe[OE_GENERAL_OUT_THREE]
        |-> pins_o.g3_oe && !pins_o.g3_o)
        else $error("third pin not driven low");

    chk_first_pin_input: assert property (
        s_q.cfga[CA_FIRST_PIN_INPUT_SELECT] |-> !pins_o.g1_oe
        && (pins_o.g2_oe || s_q.io1_lvl) && (pins_o.g2_o == s_q.io1_lvl))
        else $error("second output does not follow first pin input");

    chk_second_buffer: assert property (
        !s_q.cfga[CA_FIRST_PIN_INPUT_SELECT] && s_q.oe[OE_GENERAL_OUT_TWO_CTL]
        |-> pins_o.g2_oe == s_q.cfga[CA_SECOND_OUTPUT_BUFFER_TYPE])
        else $error("second output buffer type wrong");

    chk_locked_write: assert property (
        wr_ok && prot_hit && !s_q.unlock && !seq_update_i
        |=> $stable(s_q.oe) && $stable(s_q.cfga) && $stable(s_q.cfgb))
        else $error("locked write changed a register");

    chk_unlocked_write: assert property (
        wr_ok && s_q.unlock && hit(wb_req_i.adr, IDX_OUTPUT_ENABLE_CTRL) && !seq_update_i
        |=> cfg_o.switch_three_enable == $past(wb_req_i.dat[3])
        && cfg_o.switch_two_enable == $past(wb_req_i.dat[2]) && !s_q.unlock)
        else $error("unlocked write to enable register lost");

    chk_seq_update: assert property (
        seq_update_i |=> cfg_o.linear_reg_enable == $past(seq_ldo_en_i)
        && cfg_o.switch_one_enable == $past(seq_switch_one_enable_i))
        else $error("sequencer update not applied");

    chk_pg_fall: assert property (
        !s_q.pg_lvl |=> !power_good_o)
        else $error("power-good held during fault");

    chk_pg_rise: assert property (
        $rose(power_good_o) |-> $past(s_q.pg_cnt) == $past(pg_lim) - 32'h1)
        else $error("power-good rose before its delay");

    chk_pb_time: assert property (
        $rose(pb_reset_o) |-> $past(s_q.pb_cnt) == $past(pb_lim) - 32'h1 ##1 !pb_reset_o)
        else $error("push-button reset at wrong hold time");

    chk_reserved_zero: assert property (
        s_q.oe[7] == 1'b0 && s_q.cfgb[5:4] == 2'b00)
        else $error("reserved bit became set");

    chk_ack_single: assert property (
        wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");

    chk_limit_write: assert property (
        wr_ok && s_q.unlock && hit(wb_req_i.adr, IDX_SYSTEM_CONFIG_B)
        |=> cfg_o.switch_three_current_limit == $past(wb_req_i.dat[3:2])
        && cfg_o.switch_two_current_limit == $past(wb_req_i.dat[1:0]))
        else $error("current limit write lost");

    chk_tight_write: assert property (
        wr_ok && s_q.unlock && hit(wb_req_i.adr, IDX_SYSTEM_CONFIG_A)
        |=> cfg_o.overvolt_monitor_en == $past(wb_req_i.dat[CA_SUPERVISOR_TIGHT_LIMITS])
        && cfg_o.supervisor_tight_limits == cfg_o.overvolt_monitor_en)
        else $error("supervisor strictness write lost");

    chk_first_pin_drive: assert property (
        !s_q.cfga[CA_FIRST_PIN_INPUT_SELECT] && !s_q.oe[OE_GENERAL_OUT_ONE_CTL]
        |-> pins_o.g1_oe && !pins_o.g1_o)
        else $error("first pin not driven low");

    chk_warm_reset_off: assert property (
        !s_q.cfgb[CB_WARM_RESET_PIN_SELECT] |-> !dcdc12_warm_rst_o)
        else $error("warm reset raised in output mode");

    chk_pb_release: assert property (
        s_q.pb_lvl |=> !pb_reset_o)
        else $error("push-button reset while released");

    chk_pg_hold: assert property (
        power_good_o && s_q.pg_lvl |=> power_good_o)
        else $error("power-good dropped while supply good");

    chk_read_reserved: assert property (
        acc && !wb_req_i.we && hit(wb_req_i.adr, IDX_OUTPUT_ENABLE_CTRL)
        |=> wb_rsp_o.ack && !wb_rsp_o.dat[7])
        else $error("reserved enable bit read back set");

    chk_unlock_arm: assert property (
        wr_ok && hit(wb_req_i.adr, IDX_PASSWORD) && wb_req_i.dat[7:0] == PW_KEY
        |=> s_q.unlock)
        else $error("password key did not unlock");

    cov_unlocked_write: cover property (wr_ok && s_q.unlock && prot_hit);
    cov_locked_write: cover property (wr_ok && !s_q.unlock && prot_hit);
    cov_pb_fire: cover property ($rose(pb_reset_o));
    cov_pg_rise: cover property ($rose(power_good_o));
    cov_seq_update: cover property (seq_update_i);
endmodule : pec_regs

// ==== verif/pec_regs_test.sv ====
// Self-checking testbench for the enable and configuration register bank
`timescale 1ns/10ps
module pec_regs_test;
    import pec_pkg::*;
    // ------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pec_wb_req_t req = '0;
    pec_wb_rsp_t rsp;
    pec_pin_in_t pin = '{g1: 1'b0, g3: 1'b1, pb_n: 1'b1, pg_in: 1'b0};
    pec_pins_t pins;
    pec_cfg_t cfg;
    logic seq_upd = 1'b0;
    logic seq_ldo = 1'b0;
    logic seq_ls1 = 1'b0;
    logic warm_rst, pb_rst, pgood;
    int fails = 0;
    int checked = 0;
    int cyc_cnt = 0;
    logic [31:0] rd;
    // Short timer counts keep every delay code reachable within the run
    localparam logic [31:0] TB_PB_SHORT = 32'h14;
    localparam logic [31:0] TB_PB_LONG = 32'h28;
    localparam logic [31:0] TB_PGD_0 = 32'h5;
    localparam logic [31:0] TB_PGD_1 = 32'h8;
    localparam logic [31:0] TB_PGD_2 = 32'hc;
    localparam logic [31:0] TB_PGD_3 = 32'h10;
    int lim_pg[4] = '{TB_PGD_0, TB_PGD_1, TB_PGD_2, TB_PGD_3};
    pec_regs #(.PB_SHORT_CYC(TB_PB_SHORT), .PB_LONG_CYC(TB_PB_LONG), .PGD_0_CYC(TB_PGD_0),
        .PGD_1_CYC(TB_PGD_1), .PGD_2_CYC(TB_PGD_2), .PGD_3_CYC(TB_PGD_3)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .pin_i(pin),
        .pins_o(pins), .seq_update_i(seq_upd), .seq_ldo_en_i(seq_ldo),
        .seq_switch_one_enable_i(seq_ls1), .cfg_o(cfg), .dcdc12_warm_rst_o(warm_rst),
        .pb_reset_o(pb_rst), .power_good_o(pgood));
    always #4 clk_i = ~clk_i;
    // Generous ceiling: the whole run needs well under two thousand cycles
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Classic single cycle; waits for ack without assuming its latency
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx[5:0], 2'b00}, sel: 4'h1,
            dat: {24'h0, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        r = rsp.dat;
        req <= '0;
    endtask : bus
    task automatic uw(input logic [7:0] idx, input logic [7:0] d);
        bus(IDX_PASSWORD, 1'b1, PW_KEY, rd);
        bus(idx, 1'b1, d, rd);
    endtask : uw
    task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00, rd);
        chk(nm, {24'h0, exp}, rd);
    endtask : rchk
    task automatic settle();
        repeat (6) @(posedge clk_i);
    endtask : settle
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk("enable rst", IDX_OUTPUT_ENABLE_CTRL, 8'h00);
        rchk("cfg_a rst", IDX_SYSTEM_CONFIG_A, 8'h48);
        rchk("cfg_b rst", IDX_SYSTEM_CONFIG_B, 8'hc0);
        rchk("unmapped", 8'h3f, 8'h00);
        chk("g2 drive", 32'h1, {31'h0, pins.g2_oe});
        chk("g1 drive", 32'h1, {31'h0, pins.g1_oe});
        chk("g3 input", 32'h0, {31'h0, pins.g3_oe});
        chk("delay rst", 32'h1, {30'h0, cfg.power_good_delay});
        chk("cfg rst", 32'h18, {27'h0, cfg.warm_reset_pin_select, cfg.undervolt_hyst,
            cfg.first_pin_input_select, cfg.undervolt_level});
        chk("pin lows", 32'h0, {30'h0, pins.g1_o, pins.g3_o});
        pin.g3 <= 1'b0;
        settle();
        chk("warm low", 32'h1, {31'h0, warm_rst});
        pin.g3 <= 1'b1;
        settle();
        chk("warm high", 32'h0, {31'h0, warm_rst});
        $display("test reset done");
    endtask : t_reset
    task automatic t_lock();
        bus(IDX_OUTPUT_ENABLE_CTRL, 1'b1, 8'h0f, rd);
        rchk("locked wr", IDX_OUTPUT_ENABLE_CTRL, 8'h00);
        bus(IDX_PASSWORD, 1'b1, PW_KEY, rd);
        bus(8'h3f, 1'b1, 8'h55, rd);
        bus(IDX_OUTPUT_ENABLE_CTRL, 1'b1, 8'h0f, rd);
        rchk("spent unlock", IDX_OUTPUT_ENABLE_CTRL, 8'h00);
        $display("test lock done");
    endtask : t_lock
    task automatic t_enable();
        uw(IDX_OUTPUT_ENABLE_CTRL, 8'hff);
        rchk("enable rsvd", IDX_OUTPUT_ENABLE_CTRL, 8'h7f);
        chk("switches", 32'hf, {28'h0, cfg.switch_three_enable, cfg.switch_two_enable,
            cfg.switch_one_enable, cfg.linear_reg_enable});
        chk("g1 hiz", 32'h0, {31'h0, pins.g1_oe});
        chk("g2 high", 32'h3, {30'h0, pins.g2_o, pins.g2_oe});
        uw(IDX_OUTPUT_ENABLE_CTRL, 8'h40);
        chk("g3 ignored", 32'h0, {31'h0, pins.g3_oe});
        uw(IDX_SYSTEM_CONFIG_B, 8'h3f);
        rchk("cfg_b rsvd", IDX_SYSTEM_CONFIG_B, 8'h0f);
        chk("cfg_b flags", 32'h0, {30'h0, cfg.warm_reset_pin_select, cfg.undervolt_hyst});
        chk("g3 hiz", 32'h0, {31'h0, pins.g3_oe});
        uw(IDX_OUTPUT_ENABLE_CTRL, 8'h00);
        chk("g3 low", 32'h1, {31'h0, pins.g3_oe});
        chk("off", 32'h0, {28'h0, cfg.switch_three_enable, cfg.switch_two_enable,
            cfg.switch_one_enable, cfg.linear_reg_enable});
        for (int c = 0; c < 4; c++) begin
            uw(IDX_SYSTEM_CONFIG_B, {4'h0, 2'(c), 2'(3 - c)});
            chk("ilim three", 32'(c), {30'h0, cfg.switch_three_current_limit});
            chk("ilim two", 32'(3 - c), {30'h0, cfg.switch_two_current_limit});
        end
        $display("test enable done");
    endtask : t_enable
    task automatic t_insel();
        uw(IDX_SYSTEM_CONFIG_A, 8'h64);
        chk("tight", 32'h3, {30'h0, cfg.supervisor_tight_limits,
            cfg.overvolt_monitor_en});
        chk("g1 input", 32'h0, {31'h0, pins.g1_oe});
        chk("insel flag", 32'h1, {31'h0, cfg.first_pin_input_select});
        pin.g1 <= 1'b1;
        settle();
        chk("g2 pp high", 32'h3, {30'h0, pins.g2_o, pins.g2_oe});
        pin.g1 <= 1'b0;
        settle();
        chk("g2 pp low", 32'h1, {30'h0, pins.g2_o, pins.g2_oe});
        uw(IDX_SYSTEM_CONFIG_A, 8'h20);
        pin.g1 <= 1'b1;
        settle();
        chk("g2 od rel", 32'h0, {31'h0, pins.g2_oe});
        uw(IDX_SYSTEM_CONFIG_A, 8'h03);
        chk("wide", 32'h3, {28'h0, cfg.supervisor_tight_limits,
            cfg.overvolt_monitor_en, cfg.undervolt_level});
        chk("g1 out", 32'h1, {31'h0, pins.g1_oe});
        $display("test input select done");
    endtask : t_insel
    task automatic t_pgood();
        int n;
        for (int c = 0; c < 4; c++) begin
            uw(IDX_SYSTEM_CONFIG_A, {3'b000, 2'(c), 3'b000});
            pin.pg_in <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (pgood !== 1'b1 && n < 100);
            chk("pg rise", 32'h1, 32'(n >= lim_pg[c] && n <= lim_pg[c] + 5));
            pin.pg_in <= 1'b0;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (pgood !== 1'b0 && n < 100);
            chk("pg fall", 32'h1, 32'(n <= 6));
        end
        $display("test power good done");
    endtask : t_pgood
    task automatic t_pbutton();
        int n;
        int lim;
        for (int b = 0; b < 2; b++) begin
            lim = (b == 1) ? int'(TB_PB_LONG) : int'(TB_PB_SHORT);
            uw(IDX_SYSTEM_CONFIG_A, {1'(b), 7'h00});
            pin.pb_n <= 1'b0;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (pb_rst !== 1'b1 && n < 100);
            chk("pb hold", 32'h1, 32'(n >= lim && n <= lim + 6));
            pin.pb_n <= 1'b1;
            settle();
        end
        $display("test push button done");
    endtask : t_pbutton
    task automatic t_seq();
        @(posedge clk_i);
        seq_upd <= 1'b1;
        seq_ldo <= 1'b1;
        seq_ls1 <= 1'b1;
        @(posedge clk_i);
        seq_upd <= 1'b0;
        rchk("seq load", IDX_OUTPUT_ENABLE_CTRL, 8'h03);
        $display("test sequencer done");
    endtask : t_seq
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_lock();
        t_enable();
        t_insel();
        t_pgood();
        t_pbutton();
        t_seq();
        report_and_stop();
    end
endmodule : pec_regs_test
